// file: hdl/tpc_ctrl.sv
// PHY control, link status and symbol path for a four-pair twisted-pair PHY.
// Assumes all inputs synchronous to pclk; symbols are one per pclk cycle.
`default_nettype none
module tpc_ctrl
   import tpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic an_complete,
   input wire logic [1:0] link_control,
   input wire logic an_master,
   input wire logic loc_rcvr_ok,
   input wire logic rem_rcvr_ok,
   input wire logic scr_ok,
   input wire logic rem_lpi_req,
   input wire logic rem_update_done,
   output logic [1:0] link_status,
   output logic [1:0] tx_mode,
   output logic config_master,
   output logic lpi_mode,
   output logic loc_lpi_req,
   output logic loc_update_done,
   output logic loc_rcvr_report,
   input wire logic [11:0] pcs_tx_vec,
   output logic [11:0] mdi_tx_vec,
   input wire logic [11:0] mdi_rx_vec,
   input wire logic mdi_rx_valid,
   output logic [11:0] pcs_rx_vec,
   output logic pcs_rx_valid
);
   // ****************************************************************
   // Register interface
   // ****************************************************************
   logic [31:0] ctrl, next_ctrl;
   logic [31:0] pmap, next_pmap;
   logic [31:0] status;
   logic acc, wr, hit;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign hit = (paddr == TPC_CTRL_OFS) || (paddr == TPC_STAT_OFS) || (paddr == TPC_MAP_OFS);
   assign pready = 1'b1;
   assign pslverr = acc && !hit;

   always_comb begin
      next_ctrl = ctrl;
      next_pmap = pmap;
      if (wr && paddr == TPC_CTRL_OFS) begin
         next_ctrl = {29'h0, pwdata[2:0]};
      end
      if (wr && paddr == TPC_MAP_OFS) begin
         next_pmap = {20'h0, pwdata[11:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= TPC_CTRL_RST;
         pmap <= TPC_MAP_RST;
      end else begin
         ctrl <= next_ctrl;
         pmap <= next_pmap;
      end
   end

   always_comb begin
      case (paddr)
         TPC_CTRL_OFS: prdata = ctrl;
         TPC_STAT_OFS: prdata = status;
         TPC_MAP_OFS: prdata = pmap;
         default: prdata = 32'h0;
      endcase
   end

   // ****************************************************************
   // PHY control state machine
   // ****************************************************************
   tpc_state_e state, next_state;
   logic [7:0] tmr, next_tmr;
   logic both_ok, enabled, eee;
   assign both_ok = loc_rcvr_ok && rem_rcvr_ok;
   // Scan and disable requests both hold the state machine in OFF, transmit at zero and receive valid low.
   assign enabled = an_complete && (link_control == TPC_LC_ENABLE);
   assign eee = ctrl[TPC_CTRL_EEE];

   always_comb begin
      next_state = state;
      next_tmr = (tmr == 8'h0) ? 8'h0 : tmr - 8'h1;
      if (!enabled) begin
         next_state = TPC_S_OFF;
         next_tmr = 8'h0;
      end else begin
         case (state)
            TPC_S_OFF: next_state = TPC_S_TRAIN;
            TPC_S_TRAIN: begin
               if (both_ok) begin
                  next_state = TPC_S_NORMAL;
               end
            end
            TPC_S_NORMAL: begin
               if (!both_ok) begin
                  next_state = TPC_S_TRAIN;
               end else if (eee && ctrl[TPC_CTRL_LPIREQ] && rem_lpi_req) begin
                  next_state = TPC_S_LPI_QUIET;
                  next_tmr = 8'(TPC_QUIET_CYC);
               end
            end
            TPC_S_LPI_QUIET: begin
               // Leaving LPI is taken on any side dropping its request.
               if (!eee || !ctrl[TPC_CTRL_LPIREQ] || !rem_lpi_req) begin
                  next_state = TPC_S_TRAIN;
               end else if (tmr == 8'h0) begin
                  next_state = TPC_S_LPI_REFR;
                  next_tmr = 8'(TPC_REFR_CYC);
               end
            end
            TPC_S_LPI_REFR: begin
               if (!eee || !ctrl[TPC_CTRL_LPIREQ] || !rem_lpi_req) begin
                  next_state = TPC_S_TRAIN;
               end else if (tmr == 8'h0) begin
                  next_state = TPC_S_LPI_QUIET;
                  next_tmr = 8'(TPC_QUIET_CYC);
               end
            end
            default: next_state = TPC_S_OFF;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= TPC_S_OFF;
         tmr <= 8'h0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
      end
   end

   // ****************************************************************
   // Mode, link status and indications
   // ****************************************************************
   logic [1:0] next_link, next_mode;
   logic next_upd;
   always_comb begin
      next_mode = TPC_SEND_I;
      next_link = TPC_LINK_FAIL;
      next_upd = 1'b0;
      case (state)
         TPC_S_NORMAL: begin
            next_mode = TPC_SEND_N;
            next_link = TPC_LINK_OK;
         end
         TPC_S_TRAIN: next_link = loc_rcvr_ok ? TPC_LINK_OK : TPC_LINK_READY;
         TPC_S_LPI_QUIET: begin
            next_mode = TPC_SEND_Z;
            next_link = TPC_LINK_OK;
            next_upd = 1'b1;
         end
         TPC_S_LPI_REFR: begin
            next_mode = TPC_SEND_I;
            next_link = TPC_LINK_OK;
            next_upd = loc_rcvr_ok;
         end
         default: begin
            next_mode = TPC_SEND_I;
            next_link = enabled ? TPC_LINK_READY : TPC_LINK_FAIL;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_status <= TPC_LINK_FAIL;
         tx_mode <= TPC_SEND_I;
         loc_update_done <= 1'b0;
      end else begin
         link_status <= next_link;
         tx_mode <= next_mode;
         loc_update_done <= next_upd;
      end
   end

   assign config_master = an_master;
   assign lpi_mode = (state == TPC_S_LPI_QUIET) || (state == TPC_S_LPI_REFR);
   assign loc_lpi_req = eee && ctrl[TPC_CTRL_LPIREQ];
   // Forced retraining reports the local receiver as unreliable to the far end.
   assign loc_rcvr_report = loc_rcvr_ok && !ctrl[TPC_CTRL_RETRAIN];

   // ****************************************************************
   // Transmit and receive symbol paths
   // ****************************************************************
   logic [11:0] next_tx, next_rx;
   logic [TPC_SYW-1:0] s;
   always_comb begin
      next_tx = 12'h0;
      next_rx = 12'h0;
      s = 3'h0;
      for (int i = 0; i < TPC_PAIRS; i++) begin
         s = pcs_tx_vec[i*TPC_SYW +: TPC_SYW];
         // Clamp out-of-range codes to the +/-2 rails.
         if ($signed(s) > 3'sd2 || $signed(s) < -3'sd2) begin
            s = s[2] ? 3'b110 : 3'b010;
         end
         if (tx_mode == TPC_SEND_Z) begin
            s = 3'h0;
         end else if (tx_mode == TPC_SEND_I && s[0]) begin
            s = 3'h0;
         end
         next_tx[i*TPC_SYW +: TPC_SYW] = s;
         s = mdi_rx_vec[pmap[2*i +: 2]*TPC_SYW +: TPC_SYW];
         if (pmap[TPC_MAP_INV+i]) begin
            s = 3'(-$signed(s));
         end
         next_rx[i*TPC_SYW +: TPC_SYW] = s;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mdi_tx_vec <= 12'h0;
         pcs_rx_vec <= 12'h0;
         pcs_rx_valid <= 1'b0;
      end else begin
         mdi_tx_vec <= enabled ? next_tx : 12'h0;
         pcs_rx_vec <= next_rx;
         pcs_rx_valid <= mdi_rx_valid && enabled;
      end
   end

   always_comb begin
      status = 32'h0;
      status[TPC_ST_LINK +: 2] = link_status;
      status[TPC_ST_MODE +: 2] = tx_mode;
      status[TPC_ST_STATE +: 3] = state;
      status[TPC_ST_CFG] = an_master;
      status[TPC_ST_LOC] = loc_rcvr_ok;
      status[TPC_ST_REM] = rem_rcvr_ok;
      status[TPC_ST_SCR] = scr_ok;
      status[TPC_ST_UPD] = rem_update_done;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   // A scan request first forces the state to OFF, and the registered status follows one
   // edge later, so the check allows two edges.
   AST_DISABLED_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
      (link_control == TPC_LC_SCAN) |-> ##2 (link_status == TPC_LINK_FAIL))
      else $error("link not FAIL under scan");
   // The mode register lags the state by one edge and the state lags both_ok by one more.
   AST_NORMAL_NEEDS_OK: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_mode == TPC_SEND_N) |-> $past(both_ok, 2))
      else $error("normal mode without both receivers reliable");
   AST_OFF_NO_TX: assert property (@(posedge pclk) disable iff (!presetn)
      !enabled |=> (mdi_tx_vec == 12'h0))
      else $error("transmit while not enabled");
   AST_IDLE_EVEN: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(tx_mode) == TPC_SEND_I) |-> !(mdi_tx_vec[0] | mdi_tx_vec[3] | mdi_tx_vec[6]
      | mdi_tx_vec[9]))
      else $error("odd level in idle");
   AST_ZERO_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(tx_mode) == TPC_SEND_Z) |-> (mdi_tx_vec == 12'h0))
      else $error("nonzero symbol in zero mode");
   AST_START_TRAIN: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_OFF && enabled) |=> (state == TPC_S_TRAIN))
      else $error("start-up did not enter training");
   AST_LINK_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
      link_status != 2'b11)
      else $error("illegal link status");
   AST_LPI_NEEDS_EEE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(lpi_mode) |-> $past(eee && rem_lpi_req))
      else $error("LPI entered without capability and requests");

   // ****************************************************************
   // State and output sequencing checks
   // ****************************************************************
   AST_LINK_FAIL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_OFF && !enabled) |=> (link_status == TPC_LINK_FAIL))
      else $error("link not FAIL while off and not enabled");
   AST_MODE_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
      tx_mode != 2'b11)
      else $error("illegal transmit mode");
   AST_NORMAL_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_NORMAL) |=> (link_status == TPC_LINK_OK && tx_mode == TPC_SEND_N))
      else $error("normal state outputs wrong");
   AST_TRAIN_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_TRAIN) |=> (tx_mode == TPC_SEND_I))
      else $error("training not idle only");
   AST_TRAIN_READY: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_TRAIN && !loc_rcvr_ok) |=> (link_status == TPC_LINK_READY))
      else $error("training link not READY");
   AST_QUIET_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_LPI_QUIET) |=> (tx_mode == TPC_SEND_Z && loc_update_done))
      else $error("quiet period outputs wrong");
   AST_REFR_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_LPI_REFR) |=> (tx_mode == TPC_SEND_I))
      else $error("refresh not idle");
   AST_QUIET_TO_REFR: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_LPI_QUIET && enabled && eee && ctrl[TPC_CTRL_LPIREQ] && rem_lpi_req
      && tmr == 8'h0) |=> (state == TPC_S_LPI_REFR))
      else $error("quiet period did not end in refresh");
   AST_REFR_TO_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_LPI_REFR && enabled && eee && ctrl[TPC_CTRL_LPIREQ] && rem_lpi_req
      && tmr == 8'h0) |=> (state == TPC_S_LPI_QUIET))
      else $error("refresh did not return to quiet");
   AST_DROP_TO_TRAIN: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_NORMAL && enabled && !both_ok) |=> (state == TPC_S_TRAIN))
      else $error("unreliable receiver kept normal mode");
   AST_NORMAL_TO_LPI: assert property (@(posedge pclk) disable iff (!presetn)
      (state == TPC_S_NORMAL && enabled && both_ok && eee && ctrl[TPC_CTRL_LPIREQ]
      && rem_lpi_req) |=> (state == TPC_S_LPI_QUIET))
      else $error("LPI not entered on both requests");
   AST_LPI_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
      (lpi_mode && enabled && !rem_lpi_req) |=> (state == TPC_S_TRAIN))
      else $error("LPI not left when remote request drops");
   AST_NO_LPI_WITHOUT_EEE: assert property (@(posedge pclk) disable iff (!presetn)
      (!eee && !lpi_mode) |=> !lpi_mode)
      else $error("LPI entered without capability");
   AST_DISABLE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !enabled |=> (state == TPC_S_OFF))
      else $error("processes running while disabled");
   AST_RX_VALID_GATED: assert property (@(posedge pclk) disable iff (!presetn)
      !enabled |=> !pcs_rx_valid)
      else $error("receive valid while not enabled");
   AST_RX_VALID_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
      enabled |=> (pcs_rx_valid == $past(mdi_rx_valid)))
      else $error("receive valid not forwarded");
   AST_CFG_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
      config_master == an_master)
      else $error("configuration not continuous");
   AST_REPORT_RETRAIN: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl[TPC_CTRL_RETRAIN] |-> !loc_rcvr_report)
      else $error("forced retrain not reported");
   // Codes three, minus three and minus four are outside the five levels.
   AST_TX_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      !(mdi_tx_vec[2:0] inside {3'b011, 3'b100, 3'b101})
      && !(mdi_tx_vec[5:3] inside {3'b011, 3'b100, 3'b101})
      && !(mdi_tx_vec[8:6] inside {3'b011, 3'b100, 3'b101})
      && !(mdi_tx_vec[11:9] inside {3'b011, 3'b100, 3'b101}))
      else $error("transmit symbol out of range");

   // ****************************************************************
   // Register bus checks
   // ****************************************************************
   AST_PREADY_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> pready)
      else $error("access without ready");
   AST_SLVERR_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> (psel && penable && !hit))
      else $error("error response outside unmapped access");
   AST_UNMAPPED_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && !hit) |=> ($stable(ctrl) && $stable(pmap)))
      else $error("unmapped write changed a register");
   AST_PRDATA_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && !hit && !pwrite) |-> (prdata == 32'h0))
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: hdl/tpc_pkg.sv
// Constants, register map and encodings for the twisted-pair PHY control block.
// Assumes one 25 MHz APB clock; symbol streams are sampled on that same clock.
`default_nettype none
package tpc_pkg;
   localparam int TPC_PAIRS = 4;
   localparam int TPC_SYW = 3;
   localparam int TPC_VW = TPC_PAIRS * TPC_SYW;
   // Register byte offsets.
   localparam logic [7:0] TPC_CTRL_OFS = 8'h00;
   localparam logic [7:0] TPC_STAT_OFS = 8'h04;
   localparam logic [7:0] TPC_MAP_OFS = 8'h08;
   // Control register fields.
   localparam int TPC_CTRL_EEE = 0;
   localparam int TPC_CTRL_LPIREQ = 1;
   localparam int TPC_CTRL_RETRAIN = 2;
   localparam logic [31:0] TPC_CTRL_RST = 32'h0000_0000;
   // Pair map: 2-bit source pair per lane, bit 8..11 polarity invert.
   localparam logic [31:0] TPC_MAP_RST = 32'h0000_00e4;
   localparam int TPC_MAP_INV = 8;
   // Status fields.
   localparam int TPC_ST_LINK = 0;
   localparam int TPC_ST_MODE = 2;
   localparam int TPC_ST_STATE = 4;
   localparam int TPC_ST_CFG = 8;
   localparam int TPC_ST_LOC = 9;
   localparam int TPC_ST_REM = 10;
   localparam int TPC_ST_SCR = 11;
   localparam int TPC_ST_UPD = 12;
   // Time allowed for the remote receiver to train, in ns; no timer in tpc_ctrl uses it.
   localparam int TPC_TRAIN_NS = 2000;
   localparam int TPC_CLK_NS = 40;
   localparam int TPC_TRAIN_CYC = TPC_TRAIN_NS / TPC_CLK_NS;
   // Quiet cycles in LPI before a refresh burst.
   localparam int TPC_QUIET_NS = 800;
   localparam int TPC_QUIET_CYC = TPC_QUIET_NS / TPC_CLK_NS;
   localparam int TPC_REFR_CYC = 4;

   typedef enum logic [1:0] {
      TPC_LINK_FAIL = 2'b00,
      TPC_LINK_READY = 2'b01,
      TPC_LINK_OK = 2'b10
   } tpc_link_e;
   typedef enum logic [1:0] {
      TPC_LC_SCAN = 2'b00,
      TPC_LC_DISABLE = 2'b01,
      TPC_LC_ENABLE = 2'b10
   } tpc_lctl_e;
   typedef enum logic [1:0] {
      TPC_SEND_N = 2'b00,
      TPC_SEND_I = 2'b01,
      TPC_SEND_Z = 2'b10
   } tpc_txmode_e;
   typedef enum logic [2:0] {
      TPC_S_OFF = 3'b000,
      TPC_S_TRAIN = 3'b001,
      TPC_S_NORMAL = 3'b010,
      TPC_S_LPI_QUIET = 3'b011,
      TPC_S_LPI_REFR = 3'b100
   } tpc_state_e;
endpackage
`default_nettype wire

// file: tb/tpc_far.sv
// Far-side model: negotiation requests and the remote receiver status.
// Assumes the bench steps the phase input; outputs change just after pclk rises.
`default_nettype none
module tpc_far
   import tpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] phase,
   input wire logic rem_ok_in,
   input wire logic lpi_in,
   output logic an_complete,
   output logic [1:0] link_control,
   output logic rem_rcvr_ok,
   output logic rem_lpi_req,
   output logic rem_update_done
);
   timeunit 1ns;
   timeprecision 1ns;
   // Phase 3 hands over control before negotiation is complete, on purpose.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         an_complete <= 1'b0;
         link_control <= TPC_LC_SCAN;
         rem_rcvr_ok <= 1'b0;
         rem_lpi_req <= 1'b0;
         rem_update_done <= 1'b0;
      end else begin
         an_complete <= (phase == 2'd2);
         link_control <= (phase == 2'd0) ? TPC_LC_SCAN :
            (phase == 2'd1) ? TPC_LC_DISABLE : TPC_LC_ENABLE;
         rem_rcvr_ok <= rem_ok_in && (phase == 2'd2);
         rem_lpi_req <= lpi_in;
         rem_update_done <= lpi_in;
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_twisted_pair_phy_control_link.sv
// Self-checking bench for tpc_ctrl with APB master and symbol path model.
// Assumes one 25 MHz clock and the far-side model in tpc_far.
`default_nettype none
module tb_twisted_pair_phy_control_link
   import tpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, rnd = 32'h20e5, map_m = TPC_MAP_RST;
   logic pready, pslverr, an_complete, an_master = 1, loc_ok = 0, scr_ok = 1;
   logic rem_ok_in = 0, lpi_in = 0, rem_rcvr_ok, rem_lpi_req, rem_upd, err;
   logic [1:0] phase = 0, link_control, link_status, tx_mode;
   logic config_master, lpi_mode, loc_lpi_req, loc_update_done, loc_rcvr_report;
   logic [11:0] pcs_tx_vec = '0, mdi_tx_vec, mdi_rx_vec = '0, pcs_rx_vec, exp_tx, exp_rx;
   logic mdi_rx_valid = 0, pcs_rx_valid, exp_v, en, en_d = 0, vc = 0;
   logic [2:0] s;
   int n_mismatch = 0, n_tests = 0, k;
   tpc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .an_complete(an_complete), .link_control(link_control),
      .an_master(an_master), .loc_rcvr_ok(loc_ok), .rem_rcvr_ok(rem_rcvr_ok),
      .scr_ok(scr_ok), .rem_lpi_req(rem_lpi_req), .rem_update_done(rem_upd),
      .link_status(link_status), .tx_mode(tx_mode), .config_master(config_master),
      .lpi_mode(lpi_mode), .loc_lpi_req(loc_lpi_req), .loc_update_done(loc_update_done),
      .loc_rcvr_report(loc_rcvr_report), .pcs_tx_vec(pcs_tx_vec), .mdi_tx_vec(mdi_tx_vec),
      .mdi_rx_vec(mdi_rx_vec), .mdi_rx_valid(mdi_rx_valid), .pcs_rx_vec(pcs_rx_vec),
      .pcs_rx_valid(pcs_rx_valid));
   tpc_far far (.pclk(pclk), .presetn(presetn), .phase(phase), .rem_ok_in(rem_ok_in),
      .lpi_in(lpi_in), .an_complete(an_complete), .link_control(link_control),
      .rem_rcvr_ok(rem_rcvr_ok), .rem_lpi_req(rem_lpi_req), .rem_update_done(rem_upd));
   always #20 pclk = ~pclk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [2:0] flt(input logic [2:0] x, input logic [1:0] m);
      logic signed [2:0] v;
      v = x;
      if (m == TPC_SEND_Z) return 3'h0;
      if (v > 2) v = 2;
      if (v < -2) v = -2;
      if (m == TPC_SEND_I && v[0]) v = 0;
      return v;
   endfunction
   function automatic logic [2:0] rs(input logic [2:0] x);
      logic signed [2:0] v;
      v = x;
      return (v > 2 || v < -2) ? 3'h0 : x;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Symbols are random every cycle; rx symbols stay in the five legal levels.
   always @(posedge pclk) begin
      en = an_complete === 1'b1 && link_control === TPC_LC_ENABLE;
      for (int i = 0; i < TPC_PAIRS; i++) begin
         exp_tx[3*i+:3] = en ? flt(pcs_tx_vec[3*i+:3], tx_mode) : 3'h0;
         s = mdi_rx_vec[3*map_m[2*i+:2]+:3];
         exp_rx[3*i+:3] = map_m[TPC_MAP_INV+i] ? -s : s;
      end
      exp_v = mdi_rx_valid && en;
      vc = presetn && en === en_d;
      en_d = en;
      rnd = lfsr(rnd);
      pcs_tx_vec <= rnd[11:0];
      mdi_rx_vec <= {rs(rnd[23:21]), rs(rnd[20:18]), rs(rnd[17:15]), rs(rnd[14:12])};
      mdi_rx_valid <= rnd[24];
   end
   always @(negedge pclk) begin
      if (vc) begin
         chk("mdi_tx_vec", exp_tx, mdi_tx_vec);
         chk("pcs_rx_vec", exp_rx, pcs_rx_vec);
         chk("pcs_rx_valid", exp_v, pcs_rx_valid);
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k == 50) chk("pready", 1, 0);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(negedge pclk);
      if (w && a == TPC_MAP_OFS) map_m = d;
   endtask
   task automatic wl(input string nm, input logic [1:0] l, input logic [1:0] m);
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while ((link_status !== l || tx_mode !== m) && k < 12);
      chk("link_status", l, link_status);
      chk("tx_mode", m, tx_mode);
      $display("test %s done", nm);
   endtask
   initial begin
      #200000;
      n_mismatch++;
      conclude;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(negedge pclk);
      chk("mdi_tx_vec", 0, mdi_tx_vec);
      wl("reset", TPC_LINK_FAIL, TPC_SEND_I);
      apb(0, TPC_CTRL_OFS, 0);
      chk("ctrl", TPC_CTRL_RST, rd);
      apb(0, TPC_MAP_OFS, 0);
      chk("map", TPC_MAP_RST, rd);
      repeat (10) @(posedge pclk);
      wl("scan", TPC_LINK_FAIL, TPC_SEND_I);
      phase <= 1;
      repeat (10) @(posedge pclk);
      wl("disable", TPC_LINK_FAIL, TPC_SEND_I);
      phase <= 3;
      repeat (10) @(posedge pclk);
      wl("early", TPC_LINK_FAIL, TPC_SEND_I);
      phase <= 2;
      wl("train", TPC_LINK_READY, TPC_SEND_I);
      chk("config", an_master, config_master);
      an_master <= 0;
      repeat (30) @(posedge pclk);
      chk("config", 0, config_master);
      loc_ok <= 1;
      rem_ok_in <= 1;
      wl("normal", TPC_LINK_OK, TPC_SEND_N);
      apb(0, TPC_STAT_OFS, 0);
      chk("stat", {TPC_SEND_N, TPC_LINK_OK}, rd[3:0]);
      rem_ok_in <= 0;
      wl("remote", TPC_LINK_OK, TPC_SEND_I);
      rem_ok_in <= 1;
      wl("back", TPC_LINK_OK, TPC_SEND_N);
      apb(1, TPC_CTRL_OFS, 32'h4);
      chk("rcvr_report", 0, loc_rcvr_report);
      apb(1, TPC_CTRL_OFS, 32'h0);
      chk("rcvr_report", 1, loc_rcvr_report);
      apb(1, TPC_MAP_OFS, 32'h0000_0a1b);
      repeat (40) @(posedge pclk);
      apb(1, TPC_CTRL_OFS, 32'h3);
      chk("lpi_req", 1, loc_lpi_req);
      lpi_in <= 1;
      wl("lpi", TPC_LINK_OK, TPC_SEND_Z);
      chk("lpi_mode", 1, lpi_mode);
      chk("update_done", 1, loc_update_done);
      k = 0;
      while (tx_mode === TPC_SEND_Z && k < 40) begin
         @(negedge pclk);
         k++;
      end
      chk("quiet", TPC_QUIET_CYC + 1, k);
      lpi_in <= 0;
      wl("wake", TPC_LINK_OK, TPC_SEND_N);
      apb(0, 8'h0c, 0);
      chk("slverr", 1, err);
      chk("unmapped", 0, rd);
      presetn <= 0;
      @(negedge pclk);
      wl("rereset", TPC_LINK_FAIL, TPC_SEND_I);
      conclude;
   end
endmodule
`default_nettype wire
